// file: test/spu_remote_dev.sv
// Remote serial partner: async frames and mode 0 shift register
`timescale 1ns/1ns
module spu_remote_dev (
    input wire logic ref_clk,
    input wire spu_pkg::spu_pins_s pins,
    output logic rxdLine
);
    import spu_pkg::*;
    logic lastClk; // Shift clock one edge back
    initial rxdLine = 1'b1;
    always @(posedge ref_clk) lastClk <= pins.txdOut;
    // Idle bit, then start, data LSB first, ninth, stop
    task automatic send_frame(input logic [10:0] bits, input int n, input int len);
        rxdLine <= 1'b1;
        repeat (len) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            rxdLine <= bits[i];
            repeat (len) @(posedge ref_clk);
        end
        rxdLine <= 1'b1;
    endtask : send_frame
    // Samples TxD mid-bit from the start edge on
    task automatic grab_frame(input int len, output logic [10:0] bits);
        int k;
        k = 0;
        bits = '1;
        while (pins.txdOut !== 1'b0 && k < 20000) begin
            @(posedge ref_clk);
            k++;
        end
        repeat (len / 2) @(posedge ref_clk);
        for (int i = 0; i < 11; i++) begin
            bits[i] = pins.txdOut;
            repeat (len) @(posedge ref_clk);
        end
    endtask : grab_frame
    // Next bit after each rising shift clock; released line shows the inverse
    task automatic shift_out(input logic [7:0] d);
        int i;
        int k;
        i = 1;
        k = 0;
        rxdLine <= d[0];
        while (i < 9 && k < 4000) begin
            @(posedge ref_clk);
            k++;
            if (pins.txdOut && !lastClk && pins.rxdOe_n) begin
                rxdLine <= (i < 8) ? d[i] : ~d[7];
                i++;
            end
        end
    endtask : shift_out
    // Takes RxD at each rising shift clock while the block drives it
    task automatic shift_in(output logic [10:0] d);
        int i;
        int k;
        i = 0;
        k = 0;
        d = '0;
        while (i < 8 && k < 4000) begin
            @(posedge ref_clk);
            k++;
            if (pins.txdOut && !lastClk && !pins.rxdOe_n) begin
                d[i] = pins.rxdOut;
                i++;
            end
        end
    endtask : shift_in
endmodule : spu_remote_dev

// file: test/tb_top.sv
// Bench for the serial port: APB tasks on one side, partner on the line
`timescale 1ns/1ns
`include "spu_regs.svh"
module tb_top;
    import spu_pkg::*;
    localparam int BIT_M2 = 64; // Osc/32, osc at half ref_clk
    localparam int BIT_T1 = 192; // Double rate, reload high ff
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, rxdIn, partnerLine, md1, st;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    spu_pins_s pins;
    logic [33:0] noteQ[$]; // Expected answers {check data, error, data}
    logic [33:0] note;
    logic [10:0] frmQ[$];
    logic [10:0] gotFrm, frm;
    logic [7:0] d, ctrlV;
    logic [1:0] txMode[4] = '{2'b10, 2'b10, 2'b01, 2'b11};
    // Receive cases {mode 1, check bit, ninth, stop}
    logic [3:0] rxCase[5] = '{4'b0001, 4'b0101, 4'b0110, 4'b1100, 4'b1101};
    int failures, checked, len;
    event frmEv;
    // Block owns RxD while its enable is low
    assign rxdIn = pins.rxdOe_n ? partnerLine : pins.rxdOut;
    spu_serial_port #(.TIMER_DIV(6)) spu_serial_port_i (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxdIn(rxdIn), .pins(pins)
    );
    spu_remote_dev spu_remote_dev_i (.ref_clk(ref_clk), .pins(pins), .rxdLine(partnerLine));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic timeout();
        failures++;
        $display("CHECK FAILED %0t wait ran out", $time);
        report_and_stop();
    endtask : timeout
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_frame(input logic [10:0] got, input logic [10:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t frame %h expected %h", $time, got, exp);
        end
    endtask : cmp_frame
    // Oldest note meets each slave answer
    always @(negedge ref_clk) begin
        if (pready === 1'b1 && noteQ.size() > 0) begin
            note = noteQ.pop_front();
            cmp_word({31'h0, pslverr}, {31'h0, note[32]});
            if (note[33]) begin
                cmp_word(prdata, note[31:0]);
            end
        end
    end
    always @(frmEv) cmp_frame(gotFrm, frmQ.pop_front());
    // One APB transfer; request held until pready is seen
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] dat,
                        input logic [33:0] nt);
        int k;
        noteQ.push_back(nt);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        if (pready !== 1'b1) timeout();
        @(posedge ref_clk);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // Polls control until a flag shows
    task automatic wait_flag(input logic [7:0] m);
        int k;
        k = 0;
        rdv = '0;
        while ((rdv[7:0] & m) === 8'h00) begin
            xfer(1'b0, `SPU_OFF_CTRL, '0, '0);
            k++;
            if (k > 1000) timeout();
        end
    endtask : wait_flag
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        failures = 0;
        checked = 0;
        void'($urandom(32'h08f60f43));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        cmp_word({31'h0, pins.txdOut}, 32'h1);
        xfer(1'b0, `SPU_OFF_CTRL, '0, {2'b10, 24'h0, `SPU_CTRL_RST});
        xfer(1'b0, `SPU_OFF_BAUD, '0, {2'b10, 24'h0, `SPU_BAUD_RST});
        xfer(1'b0, `SPU_OFF_RATE, '0, {2'b10, 6'h0, `SPU_RELOAD_RST, 8'h0, `SPU_TH1_RST});
        xfer(1'b0, 12'h010, '0, {2'b01, 32'h0});
        // Mode 0 receive, then transmit with the received byte still readable
        d = 8'($urandom);
        fork
            spu_remote_dev_i.shift_out(d);
        join_none
        xfer(1'b1, `SPU_OFF_CTRL, 32'h10, '0);
        wait_flag(8'h01);
        xfer(1'b0, `SPU_OFF_BUF, '0, {2'b10, 24'h0, d});
        xfer(1'b1, `SPU_OFF_CTRL, '0, '0);
        ctrlV = 8'($urandom);
        frmQ.push_back({3'h0, ctrlV});
        fork
            begin
                spu_remote_dev_i.shift_in(gotFrm);
                ->frmEv;
            end
        join_none
        xfer(1'b1, `SPU_OFF_BUF, {24'h0, ctrlV}, '0);
        xfer(1'b0, `SPU_OFF_BUF, '0, {2'b10, 24'h0, d});
        wait_flag(8'h02);
        wait fork;
        // Async transmit in modes 2, 1 and 3
        xfer(1'b1, `SPU_OFF_RATE, 32'h03d9_00ff, '0);
        for (int m = 0; m < 4; m++) begin
            md1 = (txMode[m] != 2'b10);
            len = md1 ? BIT_T1 : BIT_M2;
            d = 8'($urandom);
            xfer(1'b1, `SPU_OFF_BAUD, {31'h0, md1}, '0);
            xfer(1'b1, `SPU_OFF_CTRL, {24'h0, txMode[m], 2'b00, m[0], 3'b000}, '0);
            frmQ.push_back({1'b1, (txMode[m] == 2'b01) ? 1'b1 : m[0], d, 1'b0});
            fork
                begin
                    spu_remote_dev_i.grab_frame(len, gotFrm);
                    ->frmEv;
                end
            join_none
            xfer(1'b1, `SPU_OFF_BUF, {24'h0, d}, '0);
            wait_flag(8'h02);
            wait fork;
        end
        // Async receive: check bit gating, stop ignored in 9-bit modes, false start
        for (int r = 0; r < 5; r++) begin
            md1 = rxCase[r][3];
            len = md1 ? BIT_T1 : BIT_M2;
            d = 8'($urandom);
            ctrlV = {md1 ? 2'b01 : 2'b10, rxCase[r][2], 5'b10000};
            frm = {rxCase[r][0], md1 ? rxCase[r][0] : rxCase[r][1], d, 1'b0};
            st = !rxCase[r][2] || frm[9];
            xfer(1'b1, `SPU_OFF_BAUD, {31'h0, md1}, '0);
            xfer(1'b1, `SPU_OFF_CTRL, {24'h0, ctrlV}, '0);
            if (md1) spu_remote_dev_i.send_frame(11'h0, 1, 36);
            spu_remote_dev_i.send_frame(frm, md1 ? 10 : 11, len);
            repeat (len) @(posedge ref_clk);
            xfer(1'b0, `SPU_OFF_CTRL, '0, {2'b10, 24'h0, ctrlV | {5'h0, frm[9] & st, 1'b0, st}});
            if (st) xfer(1'b0, `SPU_OFF_BUF, '0, {2'b10, 24'h0, d});
        end
        report_and_stop();
    end
endmodule : tb_top

// file: verilog/spu_pkg.sv
// Types shared by the serial port design
package spu_pkg;
    // Serial operating modes
    typedef enum logic [1:0] {SPU_M0, SPU_M1, SPU_M2, SPU_M3} spu_mode_e;
    // Control register layout
    typedef struct packed {
        logic modeHigh;
        logic modeLow;
        logic multiprocCheckBit;
        logic receiveEnableBit;
        logic txNinthBit;
        logic rxNinthBit;
        logic txDoneFlag;
        logic rxDoneFlag;
    } spu_ctrl_s;
    // Line pins as seen by the block
    typedef struct packed {
        logic rxdOut;
        logic rxdOe_n;
        logic txdOut;
    } spu_pins_s;
    // Receiver states
    typedef enum logic [1:0] {SPU_RX_IDLE, SPU_RX_FRAME, SPU_RX_HOLD} spu_rx_e;
endpackage : spu_pkg

// file: verilog/spu_regs.svh
// Register offsets, reset values, shift-register start values and timing counts of the serial port
`ifndef SPU_REGS_SVH
`define SPU_REGS_SVH
`define SPU_OFF_CTRL 12'h000
`define SPU_OFF_BUF 12'h004
`define SPU_OFF_BAUD 12'h008
`define SPU_OFF_RATE 12'h00c
`define SPU_CTRL_RST 8'h00
`define SPU_BAUD_RST 8'h00
`define SPU_RELOAD_RST 10'h3d9
`define SPU_TH1_RST 8'h00
`define SPU_RX_INIT_ASYNC 9'h1ff
`define SPU_RX_INIT_SYNC 8'hfe
`define SPU_PHASES 4'hc
`define SPU_T1_PRESCALE 4'h6
`define SPU_M2_DIV 6'h20
`endif

// file: verilog/spu_serial_port.sv
// Serial port with shift-register and asynchronous modes behind an APB slave
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "spu_regs.svh"
// Functional notes
// - Timer mode rate is 2^double/32 of overflows
// - Timer reload rate uses 256 minus reload high
// - Mode 0: eight bits LSB first, osc/6
// - Mode 0 write loads marker, send follows
// - Shift clock low S3-S5, shift at S6P2
// - Mode 0 done flag after final shift
// - Mode 0 receive starts on enable, flag clear
// - Mode 0 receive samples at S5P2, shifts left
// - Mode 0 receive loads buffer, sets flag
// - Mode 1 frame: start, eight data, stop
// - Async transmit starts at counter rollover
// - Mode 1 done at tenth rollover
// - Falling edge resets counter, loads 1FF
// - Majority vote of samples seven to nine
// - False start returns to idle
// - Mode 1 load gated by flag and check
// - Modes 2/3 frame carries ninth bit
// - Mode 2 rate osc/32 or osc/16
// - Modes 2/3 write loads tx ninth bit
// - Modes 2/3 done at eleventh rollover
// - Modes 2/3 load gated; resume bit later
// - Stop bit ignored in modes 2/3
// - Mode bits select among four modes
// - Buffer read and write are separate
// - Baud source select: timer or generator
module spu_serial_port #(
    parameter int TIMER_DIV = 6
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxdIn,
    output spu_pkg::spu_pins_s pins
);
    import spu_pkg::*;

    // Registers and synchronisers
    spu_ctrl_s ctrl, next_ctrl; // Control and status
    logic [7:0] rxBuf, next_rxBuf; // Receive side of the buffer
    logic doubleRateBit, next_doubleRateBit;
    logic baudGenSelect, next_baudGenSelect;
    logic [7:0] timer1ReloadHigh, next_timer1ReloadHigh;
    logic [9:0] genReload, next_genReload;
    logic rxMeta, rxSync; // Two-stage pin synchroniser
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    spu_pins_s next_pins;

    // Machine-cycle phase counter: 12 phases per cycle gives osc/6 with one ref_clk (half an osc) per phase
    logic [3:0] phase, next_phase;
    // Baud-rate sources
    logic [7:0] t1Cnt, next_t1Cnt;
    logic [3:0] t1Pre, next_t1Pre;
    logic [9:0] genCnt, next_genCnt;
    logic [5:0] m2Cnt, next_m2Cnt;
    logic halfTog, next_halfTog; // Divide-by-2 when double rate is off
    // Tick at 16x the bit rate
    logic tick16;
    // Transmit side
    logic [3:0] txDiv, next_txDiv;
    logic [8:0] txShift, next_txShift;
    logic txReq, next_txReq;
    logic txSend, next_txSend;
    logic txData, next_txData;
    logic [3:0] txWait, next_txWait;
    // Receive side
    spu_rx_e rxState, next_rxState;
    logic [3:0] rxDiv, next_rxDiv;
    logic [8:0] rxShift, next_rxShift;
    logic [2:0] votes, next_votes;
    logic rxPrev, next_rxPrev;
    logic rxFirst, next_rxFirst;
    logic m0Rx, next_m0Rx;
    logic [3:0] m0Cnt, next_m0Cnt;
    logic m0Arm, next_m0Arm;

    spu_mode_e mode;
    logic apbWr, apbRd, bufWrite, sampleBit;
    assign mode = spu_mode_e'({ctrl.modeHigh, ctrl.modeLow});
    assign apbWr = psel && penable && pwrite && !pready;
    assign apbRd = psel && penable && !pwrite && !pready;
    assign bufWrite = apbWr && (paddr == `SPU_OFF_BUF);
    assign sampleBit = (votes[0] & votes[1]) | (votes[0] & votes[2])
        | (votes[1] & votes[2]);

    // Baud tick selection; each source already carries the x16 factor
    always_comb begin
        next_phase = (phase == `SPU_PHASES - 4'h1) ? 4'h0 : phase + 4'h1;
        next_t1Pre = t1Pre;
        next_t1Cnt = t1Cnt;
        next_genCnt = genCnt + 10'h001;
        next_m2Cnt = m2Cnt + 6'h01;
        next_halfTog = halfTog;
        tick16 = 1'b0;
        // Timer 1 in auto-reload, counting osc/6; one osc period is two ref_clk
        if (t1Pre == 4'(2 * TIMER_DIV - 1)) begin
            next_t1Pre = 4'h0;
            next_t1Cnt = (t1Cnt == 8'hff) ? timer1ReloadHigh : t1Cnt + 8'h01;
        end else begin
            next_t1Pre = t1Pre + 4'h1;
        end
        if (genCnt == 10'h3ff) begin
            next_genCnt = genReload;
        end
        if (mode == SPU_M2) begin
            // Osc/32 rate means tick each 2 osc (4 ref_clk), osc/16 each osc
            tick16 = doubleRateBit ? m2Cnt[0] : (m2Cnt[1:0] == 2'b11);
        end else if (mode != SPU_M0) begin
            // Overflow from timer or generator, halved unless double rate
            if (baudGenSelect ? (genCnt == 10'h3ff)
                : (t1Pre == 4'(2 * TIMER_DIV - 1) && t1Cnt == 8'hff)) begin
                next_halfTog = !halfTog;
                tick16 = doubleRateBit || halfTog;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase <= 4'h0;
            t1Pre <= 4'h0;
            t1Cnt <= 8'h00;
            genCnt <= 10'h000;
            m2Cnt <= 6'h00;
            halfTog <= 1'b0;
        end else begin
            phase <= next_phase;
            t1Pre <= next_t1Pre;
            t1Cnt <= next_t1Cnt;
            genCnt <= next_genCnt;
            m2Cnt <= next_m2Cnt;
            halfTog <= next_halfTog;
        end
    end

    // Pin synchroniser; first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rxMeta <= 1'b1;
            rxSync <= 1'b1;
        end else begin
            rxMeta <= rxdIn;
            rxSync <= rxMeta;
        end
    end

    // Transmitter, receiver, registers and bus answer
    always_comb begin
        next_ctrl = ctrl;
        next_rxBuf = rxBuf;
        next_doubleRateBit = doubleRateBit;
        next_baudGenSelect = baudGenSelect;
        next_timer1ReloadHigh = timer1ReloadHigh;
        next_genReload = genReload;
        next_txDiv = txDiv;
        next_txShift = txShift;
        next_txReq = txReq;
        next_txSend = txSend;
        next_txData = txData;
        next_txWait = txWait;
        next_rxState = rxState;
        next_rxDiv = rxDiv;
        next_rxShift = rxShift;
        next_votes = votes;
        next_rxPrev = rxSync;
        next_rxFirst = rxFirst;
        next_m0Rx = m0Rx;
        next_m0Cnt = m0Cnt;
        next_m0Arm = m0Arm;
        next_pins = pins;
        next_prdata = 32'h0000_0000;
        next_pready = 1'b0;
        next_pslverr = 1'b0;

        // Transmitter
        if (mode == SPU_M0) begin
            // Phase 10 stands for S6P2, phase 0 for S1P1
            if (txReq && phase == 4'ha) begin
                next_txReq = 1'b0;
                next_txSend = 1'b1;
            end else if (txSend && phase == 4'ha) begin
                next_txShift = {1'b0, txShift[8:1]};
                if (txShift[8:1] == 8'h01) begin
                    next_txData = 1'b1; // Final shift done
                end
            end
            if (txData && phase == 4'h0) begin
                next_txSend = 1'b0;
                next_txData = 1'b0;
                next_ctrl.txDoneFlag = 1'b1;
            end
        end else if (tick16) begin
            next_txDiv = txDiv + 4'h1;
            if (txDiv == 4'hf) begin
                // Bit boundaries follow the free-running divider
                if (txReq) begin
                    next_txReq = 1'b0;
                    next_txSend = 1'b1;
                    next_txWait = 4'h0;
                end else if (txSend) begin
                    next_txWait = txWait + 4'h1;
                    if (!txData) begin
                        next_txData = 1'b1;
                    end else begin
                        next_txShift = {(txWait == 4'h1) && mode != SPU_M1, txShift[8:1]};
                    end
                    if (txWait == ((mode == SPU_M1) ? 4'h8 : 4'h9)) begin
                        next_txSend = 1'b0;
                        next_txData = 1'b0;
                        next_ctrl.txDoneFlag = 1'b1;
                    end
                end
            end
        end

        // Line drive
        if (mode == SPU_M0) begin
            next_pins.rxdOut = txSend ? txShift[0] : 1'b1;
            next_pins.rxdOe_n = !txSend;
            // Shift clock: low in phases 4..9 (S3..S5)
            next_pins.txdOut = !((txSend || m0Rx) && phase >= 4'h4 && phase < 4'ha);
        end else begin
            next_pins.rxdOe_n = 1'b1;
            next_pins.rxdOut = 1'b1;
            next_pins.txdOut = !txSend ? 1'b1 : (txData ? txShift[0] : 1'b0);
        end

        // Receiver
        if (mode == SPU_M0) begin
            next_rxState = SPU_RX_IDLE;
            if (!m0Rx && !m0Arm && ctrl.receiveEnableBit && !ctrl.rxDoneFlag) begin
                next_m0Arm = 1'b1;
            end
            if (m0Arm && phase == 4'ha) begin
                next_m0Arm = 1'b0;
                next_m0Rx = 1'b1;
                next_m0Cnt = 4'h0;
                next_rxShift = {1'b1, `SPU_RX_INIT_SYNC};
            end else if (m0Rx && phase == 4'ha) begin
                next_rxShift = {rxShift[7:0], rxPrev};
                next_m0Cnt = m0Cnt + 4'h1;
                if (m0Cnt == 4'h7) begin
                    // First bit in sits furthest left; reverse so it lands as LSB
                    next_rxBuf = {rxPrev, rxShift[0], rxShift[1], rxShift[2], rxShift[3],
                        rxShift[4], rxShift[5], rxShift[6]};
                end
            end
            if (m0Rx && m0Cnt == 4'h8 && phase == 4'h0) begin
                next_m0Rx = 1'b0;
                next_ctrl.rxDoneFlag = 1'b1;
            end
            // RxD level at S5P2 stands in rxPrev for the S6P2 shift
            next_rxPrev = (phase == 4'h9) ? rxSync : rxPrev;
        end else begin
            next_m0Rx = 1'b0;
            next_m0Arm = 1'b0;
            case (rxState)
                SPU_RX_IDLE: begin
                    if (ctrl.receiveEnableBit && rxPrev && !rxSync) begin
                        next_rxDiv = 4'h0;
                        next_rxShift = `SPU_RX_INIT_ASYNC;
                        next_rxFirst = 1'b1;
                        next_rxState = SPU_RX_FRAME;
                    end
                end
                SPU_RX_FRAME, SPU_RX_HOLD: begin
                    if (tick16) begin
                        next_rxDiv = rxDiv + 4'h1;
                        if (rxDiv >= 4'h6 && rxDiv <= 4'h8) begin
                            next_votes = {votes[1:0], rxSync};
                        end
                        // Rearm one bit time after the final shift, mid stop bit,
                        // so a low stop bit cannot pose as a new start edge
                        if (rxDiv == 4'h9 && rxState == SPU_RX_HOLD) begin
                            next_rxState = SPU_RX_IDLE;
                        end else if (rxDiv == 4'h9) begin
                            next_rxFirst = 1'b0;
                            if (rxFirst && sampleBit) begin
                                next_rxState = SPU_RX_IDLE;
                            end else if (!rxShift[0] && rxState == SPU_RX_FRAME) begin
                                // Start bit at rightmost (bit 0): final shift, gated load
                                if (!ctrl.rxDoneFlag && (!ctrl.multiprocCheckBit || sampleBit)) begin
                                    next_rxBuf = rxShift[8:1];
                                    next_ctrl.rxNinthBit = sampleBit;
                                    next_ctrl.rxDoneFlag = 1'b1;
                                end
                                // Modes 2/3 wait until mid stop bit before rearming
                                next_rxState = (mode == SPU_M1) ? SPU_RX_IDLE : SPU_RX_HOLD;
                            end else if (rxState == SPU_RX_FRAME) begin
                                next_rxShift = {sampleBit, rxShift[8:1]};
                            end
                        end
                    end
                end
                default: next_rxState = SPU_RX_IDLE;
            endcase
        end

        // APB slave: one wait state, writes land at the access edge
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            if (pwrite) begin
                case (paddr)
                    `SPU_OFF_CTRL: next_ctrl = spu_ctrl_s'(pwdata[7:0]);
                    `SPU_OFF_BUF: begin
                        next_txShift = {(mode == SPU_M0) ? 1'b1 : ctrl.txNinthBit,
                            pwdata[7:0]};
                        next_txReq = 1'b1;
                        next_txSend = 1'b0;
                        next_txData = 1'b0;
                    end
                    `SPU_OFF_BAUD: begin
                        next_doubleRateBit = pwdata[0];
                        next_baudGenSelect = pwdata[1];
                    end
                    `SPU_OFF_RATE: begin
                        next_timer1ReloadHigh = pwdata[7:0];
                        next_genReload = pwdata[25:16];
                    end
                    default: next_pslverr = 1'b1;
                endcase
            end else begin
                case (paddr)
                    `SPU_OFF_CTRL: next_prdata = {24'h000000, ctrl};
                    `SPU_OFF_BUF: next_prdata = {24'h000000, rxBuf};
                    `SPU_OFF_BAUD: next_prdata = {30'h0, baudGenSelect, doubleRateBit};
                    `SPU_OFF_RATE: next_prdata = {6'h00, genReload, 8'h00, timer1ReloadHigh};
                    default: next_pslverr = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl <= spu_ctrl_s'(`SPU_CTRL_RST);
            rxBuf <= 8'h00;
            doubleRateBit <= 1'b0;
            baudGenSelect <= 1'b0;
            timer1ReloadHigh <= `SPU_TH1_RST;
            genReload <= `SPU_RELOAD_RST;
            txDiv <= 4'h0;
            txShift <= 9'h000;
            txReq <= 1'b0;
            txSend <= 1'b0;
            txData <= 1'b0;
            txWait <= 4'h0;
            rxState <= SPU_RX_IDLE;
            rxDiv <= 4'h0;
            rxShift <= 9'h1ff;
            votes <= 3'h7;
            rxPrev <= 1'b1;
            rxFirst <= 1'b0;
            m0Rx <= 1'b0;
            m0Cnt <= 4'h0;
            m0Arm <= 1'b0;
            pins <= '{rxdOut: 1'b1, rxdOe_n: 1'b1, txdOut: 1'b1};
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            rxBuf <= next_rxBuf;
            doubleRateBit <= next_doubleRateBit;
            baudGenSelect <= next_baudGenSelect;
            timer1ReloadHigh <= next_timer1ReloadHigh;
            genReload <= next_genReload;
            txDiv <= next_txDiv;
            txShift <= next_txShift;
            txReq <= next_txReq;
            txSend <= next_txSend;
            txData <= next_txData;
            txWait <= next_txWait;
            rxState <= next_rxState;
            rxDiv <= next_rxDiv;
            rxShift <= next_rxShift;
            votes <= next_votes;
            rxPrev <= next_rxPrev;
            rxFirst <= next_rxFirst;
            m0Rx <= next_m0Rx;
            m0Cnt <= next_m0Cnt;
            m0Arm <= next_m0Arm;
            pins <= next_pins;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Checks
    chk_apb_answer: assert property (@(posedge ref_clk) disable iff (rst)
        (psel && penable && !pready) |=> pready) else $error("no bus answer");
    chk_async_idle: assert property (@(posedge ref_clk) disable iff (rst)
        (mode != SPU_M0 && !txSend) |=> pins.txdOut || txSend) else $error("idle not high");
    chk_m0_clock: assert property (@(posedge ref_clk) disable iff (rst)
        (mode == SPU_M0 && txSend && phase == 4'h5) |=> !pins.txdOut) else $error("clock high");
    chk_m0_drive: assert property (@(posedge ref_clk) disable iff (rst)
        (mode == SPU_M0 && txSend && !bufWrite) |=> !pins.rxdOe_n) else $error("rxd undriven");
    chk_async_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (rxState == SPU_RX_HOLD) |-> mode != SPU_M1) else $error("hold in mode 1");
    chk_start_load: assert property (@(posedge ref_clk) disable iff (rst)
        (rxState == SPU_RX_IDLE && mode != SPU_M0 && ctrl.receiveEnableBit && rxPrev && !rxSync)
        |=> rxShift == 9'h1ff && rxDiv == 4'h0) else $error("start not loaded");
    chk_tx_req: assert property (@(posedge ref_clk) disable iff (rst)
        (bufWrite && mode != SPU_M0) |=> txReq && !txSend) else $error("request lost");
    chk_m0_arm: assert property (@(posedge ref_clk) disable iff (rst)
        (m0Arm && phase == 4'ha && mode == SPU_M0) |=> m0Rx && rxShift[7:0] == 8'hfe)
        else $error("mode 0 rx start");
endmodule : spu_serial_port
